// >>> logic/spe_pkg.sv
// constants, types and helpers shared by both serial eeprom ends
//------------------------------------------------------------------
// What this block does
// RULE1 - write opcode, then address, with select low
// RULE2 - ninth address bit rides in opcode bit three
// RULE3 - programming starts only when select rises
// RULE4 - enable and write need separate select periods
// RULE5 - page write takes up to sixteen bytes
// RULE6 - only in-page address bits advance per byte
// RULE7 - in-page counter wraps and overwrites earlier bytes
// RULE8 - finished write cycle clears the write latch
// RULE9 - status write alters bits 2-4 and 7
// RULE10 - power-up leaves writes disabled and idle
// RULE11 - controller sends write enable before any write; the controller only refuses writes until the first enable has been sent
// RULE12 - controller pulses select low after power-up
// RULE13 - select rises only after whole bytes
// RULE14 - array access ignored while programming runs
// RULE15 - serial output floats at power-up
// RULE16 - bad opcode: input ignored, output floats
// RULE17 - status rewrite refreshes device after brown-out
// RULE18 - status layout: busy, latch, protect, ones, hw
// RULE19 - latch set by enable, cleared by disable
// RULE20 - status read returns ones while programming
// RULE21 - protected locations are never written
// RULE22 - sample on clock rise, drive after fall
// RULE23 - busy and latch clear together at cycle end
//------------------------------------------------------------------
package spe_pkg;

	//------------------------------------------------------------
	// opcodes and fields
	//------------------------------------------------------------
	localparam logic [7:0] write_enable_cmd  = 8'h06;
	localparam logic [7:0] write_disable_cmd = 8'h04;
	localparam logic [7:0] status_read_cmd   = 8'h05;
	localparam logic [7:0] status_write_cmd  = 8'h01;
	localparam logic [7:0] array_write_cmd   = 8'h02;
	localparam logic [7:0] ninth_bit_mask    = 8'h08;
	localparam int         ninth_bit_pos     = 3;
	localparam int         st_bp_lo          = 2;
	localparam int         st_hwp_pos        = 7;
	localparam logic [7:0] status_ones       = 8'h60;
	localparam logic [2:0] bp_reset          = 3'h0;
	localparam int         mem_bytes         = 512;
	localparam int         page_bytes        = 16;

	//------------------------------------------------------------
	// timing
	//------------------------------------------------------------
	localparam int clk_period_ns   = 100;
	localparam int write_time_us   = 5000;
	localparam int write_cycles    = write_time_us * 1000 / clk_period_ns;
	localparam int sck_half_ns     = 800;
	localparam int sck_half_cycles =
		(sck_half_ns + clk_period_ns - 1) / clk_period_ns;
	localparam int cs_gap_ns       = 800;
	localparam int cs_gap_cycles   =
		(cs_gap_ns + clk_period_ns - 1) / clk_period_ns;

	//------------------------------------------------------------
	// controller registers
	//------------------------------------------------------------
	localparam logic [7:0] reg_ctrl   = 8'h00;
	localparam logic [7:0] reg_addr   = 8'h04;
	localparam logic [7:0] reg_wdata  = 8'h08;
	localparam logic [7:0] reg_status = 8'h0C;

	//------------------------------------------------------------
	// state types
	//------------------------------------------------------------
	typedef enum logic [6:0] {
		st_idle = 7'h01,
		st_opc  = 7'h02,
		st_addr = 7'h04,
		st_data = 7'h08,
		st_stat = 7'h10,
		st_stout = 7'h20,
		st_ign  = 7'h40
	} spe_dev_st_e;

	typedef enum logic [5:0] {
		hs_wake = 6'h01,
		hs_idle = 6'h02,
		hs_low  = 6'h04,
		hs_high = 6'h08,
		hs_tail = 6'h10,
		hs_gap  = 6'h20
	} spe_host_st_e;

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	function automatic logic spe_is_arr_write(input logic [7:0] op);
		return (op & ~ninth_bit_mask) == array_write_cmd;
	endfunction

	function automatic logic spe_protected(
		input logic [8:0] a,
		input logic [2:0] b
	);
		case (b)
			3'h1: return a[8:7] == 2'h0;
			3'h2: return a[8:7] == 2'h1;
			3'h3: return a[8:7] == 2'h2;
			3'h4: return a[8:7] == 2'h3;
			3'h5: return !a[8];
			3'h6: return a[8:4] == 5'h00;
			3'h7: return a[8:4] == 5'h1F;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] spe_frame_byte(
		input logic [6:0]  idx,
		input logic [7:0]  op,
		input logic        use_addr,
		input logic [8:0]  addr,
		input logic [31:0] wdata
	);
		logic [6:0] d;
		d = idx - (use_addr ? 7'h2 : 7'h1);
		if (idx == 7'h0)
			return op | ((use_addr && addr[8]) ? ninth_bit_mask : 8'h00);
		else if (idx == 7'h1 && use_addr)
			return addr[7:0];
		else
			return wdata[{d[1:0], 3'h0} +: 8];
	endfunction

endpackage

// >>> logic/spe_link_if.sv
// link wires between the serial eeprom and its controller
interface spe_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe;
	modport dev (input cs_n, input sck, input si, output so, output so_oe);
	modport host (output cs_n, output sck, output si, input so);
endinterface

// >>> logic/spe_pin_sync.sv
// two-flop pin synchroniser with edge pulses
module spe_pin_sync #(
	parameter logic idle_level = 1'b0
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic ce,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta;
	logic prev;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta  <= idle_level;
			level <= idle_level;
			prev  <= idle_level;
		end else if (ce) begin
			meta  <= pin;
			level <= meta;
			prev  <= level;
		end
	end

	assign rise = level && !prev;
	assign fall = !level && prev;
endmodule

// >>> logic/spe_dev.sv
// serial eeprom device end: shifter, page buffer, status, array
//
// Our own choices: the register offsets and the AHB-Lite register port.
module spe_dev #(
	parameter int write_cycles = spe_pkg::write_cycles
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       ce,
	spe_link_if.dev         link,
	input  wire logic [8:0] peek_addr,
	output logic      [7:0] peek_data,
	output logic            busy,
	output logic            write_latch_flag
);
	//------------------------------------------------------------
	// declarations
	//------------------------------------------------------------
	spe_pkg::spe_dev_st_e st;
	logic        cs_n_s;
	logic        cs_rise;
	logic        cs_fall;
	logic        sck_rise;
	logic        sck_fall;
	logic        si_s;
	logic [7:0]  shreg;
	logic [7:0]  in_byte;
	logic [7:0]  outsh;
	logic [7:0]  wsr;
	logic [7:0]  status_q;
	logic [2:0]  bitcnt;
	logic [2:0]  bp;
	logic        hw_protect_enable;
	logic        ninth_address_bit;
	logic        shifting;
	logic        byte_done;
	logic        prog_stat;
	logic        fin;
	logic [4:0]  page;
	logic [3:0]  inpage;
	logic [15:0] bvalid;
	logic [7:0]  pbuf [spe_pkg::page_bytes];
	logic [7:0]  mem [spe_pkg::mem_bytes];
	logic        pend_enable;
	logic        pend_disable;
	logic        pend_status;
	logic        pend_page;
	logic [31:0] wcnt;
	logic        so_q;
	logic        so_oe_q;

	//------------------------------------------------------------
	// pin synchronisers
	//------------------------------------------------------------
	spe_pin_sync #(.idle_level(1'b1)) u_cs (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.pin     (link.cs_n),
		.level   (cs_n_s),
		.rise    (cs_rise),
		.fall    (cs_fall)
	);

	spe_pin_sync #(.idle_level(1'b0)) u_sck (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.pin     (link.sck),
		.level   (),
		.rise    (sck_rise),
		.fall    (sck_fall)
	);

	spe_pin_sync #(.idle_level(1'b0)) u_si (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.pin     (link.si),
		.level   (si_s),
		.rise    (),
		.fall    ()
	);

	//------------------------------------------------------------
	// decode
	//------------------------------------------------------------
	assign in_byte   = {shreg[6:0], si_s};
	assign shifting  = sck_rise && !cs_n_s && st != spe_pkg::st_idle
		&& st != spe_pkg::st_ign; // RULE22
	assign byte_done = shifting && bitcnt == 3'h7;
	assign fin       = busy && wcnt == 32'(write_cycles - 1);
	assign status_q  = spe_pkg::status_ones
		| {hw_protect_enable, 2'h0, bp, write_latch_flag, busy}; // RULE18
	assign link.so    = so_q;
	assign link.so_oe = so_oe_q;

	//------------------------------------------------------------
	// bit shifter
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shreg  <= 8'h00;
			bitcnt <= 3'h0;
		end else if (ce) begin
			if (cs_fall)
				bitcnt <= 3'h0;
			else if (shifting) begin
				shreg  <= in_byte;
				bitcnt <= bitcnt + 3'h1;
			end
		end
	end

	//------------------------------------------------------------
	// frame state
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= spe_pkg::st_idle; // RULE10
		end else if (ce) begin
			if (cs_rise)
				st <= spe_pkg::st_idle;
			else if (cs_fall)
				st <= spe_pkg::st_opc;
			else if (byte_done) begin
				case (st)
					spe_pkg::st_opc: begin
						if (in_byte == spe_pkg::status_read_cmd)
							st <= spe_pkg::st_stout;
						else if (busy)
							st <= spe_pkg::st_ign; // RULE14
						else if (in_byte == spe_pkg::status_write_cmd)
							st <= spe_pkg::st_stat;
						else if (spe_pkg::spe_is_arr_write(in_byte))
							st <= spe_pkg::st_addr; // RULE1
						else
							st <= spe_pkg::st_ign; // RULE16
					end
					spe_pkg::st_addr: st <= spe_pkg::st_data;
					spe_pkg::st_stat: st <= spe_pkg::st_ign;
					default: st <= st;
				endcase
			end
		end
	end

	//------------------------------------------------------------
	// commands waiting for select to rise
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_enable  <= 1'b0;
			pend_disable <= 1'b0;
			pend_status  <= 1'b0;
			pend_page <= 1'b0;
		end else if (ce) begin
			if (cs_fall || cs_rise
				|| (sck_rise && !cs_n_s && st == spe_pkg::st_ign)) begin
				// stray clocks after a complete command spoil it
				pend_enable  <= 1'b0; // RULE13
				pend_disable <= 1'b0;
				pend_status  <= 1'b0;
				pend_page    <= 1'b0;
			end else if (byte_done) begin
				if (st == spe_pkg::st_opc && !busy) begin
					pend_enable  <= in_byte == spe_pkg::write_enable_cmd;
					pend_disable <= in_byte == spe_pkg::write_disable_cmd;
				end
				if (st == spe_pkg::st_stat)
					pend_status <= 1'b1;
				if (st == spe_pkg::st_data)
					pend_page <= 1'b1;
			end
		end
	end

	//------------------------------------------------------------
	// write latch and self-timed cycle
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			write_latch_flag <= 1'b0; // RULE10
			busy             <= 1'b0;
			prog_stat        <= 1'b0;
			wcnt             <= 32'h0000_0000;
		end else if (ce) begin
			if (fin) begin
				busy             <= 1'b0; // RULE23
				write_latch_flag <= 1'b0; // RULE8
			end else if (busy)
				wcnt <= wcnt + 32'h0000_0001;
			else if (cs_rise) begin // RULE3
				if (pend_enable)
					write_latch_flag <= 1'b1; // RULE19
				else if (pend_disable)
					write_latch_flag <= 1'b0; // RULE19
				else if (write_latch_flag && (pend_status
					|| (pend_page && bitcnt == 3'h0))) begin // RULE4 RULE13
					busy      <= 1'b1;
					wcnt      <= 32'h0000_0000;
					prog_stat <= pend_status;
				end
			end
		end
	end

	//------------------------------------------------------------
	// status bits
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bp                <= spe_pkg::bp_reset;
			hw_protect_enable <= 1'b0;
		end else if (ce && fin && prog_stat) begin
			bp                <= wsr[spe_pkg::st_bp_lo +: 3]; // RULE9
			hw_protect_enable <= wsr[spe_pkg::st_hwp_pos]; // RULE9
		end
	end

	//------------------------------------------------------------
	// address and page capture
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ninth_address_bit <= 1'b0;
			page              <= 5'h00;
			inpage            <= 4'h0;
			bvalid            <= 16'h0000;
			wsr               <= 8'h00;
		end else if (ce) begin
			if (cs_fall && !busy)
				bvalid <= 16'h0000;
			else if (byte_done) begin
				case (st)
					spe_pkg::st_opc:
						ninth_address_bit <= in_byte[spe_pkg::ninth_bit_pos]; // RULE2
					spe_pkg::st_addr: begin
						page   <= {ninth_address_bit, in_byte[7:4]}; // RULE1
						inpage <= in_byte[3:0];
					end
					spe_pkg::st_data: begin
						bvalid[inpage] <= 1'b1; // RULE5
						inpage         <= inpage + 4'h1; // RULE6 RULE7
					end
					spe_pkg::st_stat: wsr <= in_byte;
					default: wsr <= wsr;
				endcase
			end
		end
	end

	// later bytes to the same slot overwrite earlier ones
	always_ff @(posedge hclk) begin
		if (ce && byte_done && st == spe_pkg::st_data)
			pbuf[inpage] <= in_byte; // RULE7
	end

	//------------------------------------------------------------
	// array programming at cycle end
	//------------------------------------------------------------
	always_ff @(posedge hclk) begin
		if (ce && fin && !prog_stat) begin
			for (int i = 0; i < spe_pkg::page_bytes; i++) begin
				if (bvalid[i] && !spe_pkg::spe_protected(
					{page, 4'(i)}, bp)) // RULE21
					mem[{page, 4'(i)}] <= pbuf[i]; // RULE14
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			peek_data <= 8'h00;
		else if (ce)
			peek_data <= mem[peek_addr];
	end

	//------------------------------------------------------------
	// status read output
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			so_q    <= 1'b0;
			so_oe_q <= 1'b0; // RULE15
			outsh   <= 8'h00;
		end else if (ce) begin
			if (byte_done && st == spe_pkg::st_opc)
				outsh <= status_q;
			if (st != spe_pkg::st_stout || cs_n_s)
				so_oe_q <= 1'b0; // RULE16
			else if (sck_fall) begin
				so_oe_q <= 1'b1; // RULE22
				so_q    <= busy ? 1'b1 : outsh[7]; // RULE20
				outsh   <= {outsh[6:0], outsh[7]};
			end
		end
	end
endmodule

// >>> logic/spe_host.sv
// serial eeprom controller end with ahb-lite command registers
module spe_host (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	spe_link_if.host         link
);
	//------------------------------------------------------------
	// declarations
	//------------------------------------------------------------
	spe_pkg::spe_host_st_e st;
	logic        wr_pend;
	logic [7:0]  wr_off;
	logic [7:0]  op;
	logic [5:0]  len;
	logic        use_addr;
	logic [8:0]  addr;
	logic [31:0] wdata;
	logic [7:0]  rx;
	logic        refused;
	logic        enable_seen;
	logic        go;
	logic        so_s;
	logic        cs_n;
	logic        sck;
	logic        si;
	logic [7:0]  hcnt;
	logic [6:0]  bidx;
	logic [6:0]  nbytes;
	logic [2:0]  bitn;
	logic [7:0]  txb;
	logic [7:0]  next_byte;
	logic        half_done;
	logic        ctrl_wr;
	logic        busy;

	spe_pin_sync #(.idle_level(1'b0)) u_so (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.pin     (link.so),
		.level   (so_s),
		.rise    (),
		.fall    ()
	);

	assign link.cs_n = cs_n;
	assign link.sck  = sck;
	assign link.si   = si;
	assign busy      = st != spe_pkg::hs_idle || go;
	assign half_done = hcnt == 8'(spe_pkg::sck_half_cycles - 1);
	assign ctrl_wr   = wr_pend && wr_off == spe_pkg::reg_ctrl;
	assign nbytes    = 7'h1 + {6'h0, use_addr} + {1'h0, len};
	assign next_byte = spe_pkg::spe_frame_byte(
		st == spe_pkg::hs_idle ? 7'h0 : bidx + 7'h1,
		op, use_addr, addr, wdata);

	//------------------------------------------------------------
	// ahb-lite slave
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			wr_off    <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (ce) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready) begin
				wr_pend <= hsel && htrans[1] && hwrite && hsize == 3'h2;
				wr_off  <= haddr[7:0];
				if (!(hsel && htrans[1] && !hwrite))
					hrdata <= 32'h0000_0000;
				else if (haddr[7:0] == spe_pkg::reg_ctrl)
					hrdata <= {15'h0, use_addr, 2'h0, len, op};
				else if (haddr[7:0] == spe_pkg::reg_addr)
					hrdata <= {23'h0, addr};
				else if (haddr[7:0] == spe_pkg::reg_wdata)
					hrdata <= wdata;
				else if (haddr[7:0] == spe_pkg::reg_status)
					hrdata <= {16'h0, rx, 5'h0, enable_seen, refused, busy};
				else
					hrdata <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op        <= 8'h00;
			len       <= 6'h00;
			use_addr  <= 1'b0;
			addr      <= 9'h000;
			wdata     <= 32'h0000_0000;
			refused   <= 1'b0;
			enable_seen <= 1'b0;
			go        <= 1'b0;
		end else if (ce) begin
			go <= 1'b0;
			if (ctrl_wr && !busy) begin
				// writes before the first enable are refused
				if (!enable_seen && (hwdata[7:0] == spe_pkg::status_write_cmd
					|| spe_pkg::spe_is_arr_write(hwdata[7:0])))
					refused <= 1'b1; // RULE11
				else begin
					refused  <= 1'b0;
					go       <= 1'b1;
					op       <= hwdata[7:0];
					len      <= hwdata[13:8];
					use_addr <= hwdata[16];
					if (hwdata[7:0] == spe_pkg::write_enable_cmd)
						enable_seen <= 1'b1;
				end
			end
			if (wr_pend && wr_off == spe_pkg::reg_addr)
				addr <= hwdata[8:0];
			if (wr_pend && wr_off == spe_pkg::reg_wdata)
				wdata <= hwdata;
		end
	end

	//------------------------------------------------------------
	// frame sequencer, clock idles low
	//------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st   <= spe_pkg::hs_wake;
			hcnt <= 8'h00;
			cs_n <= 1'b1;
			sck  <= 1'b0;
			si   <= 1'b0;
			bidx <= 7'h0;
			bitn <= 3'h0;
			txb  <= 8'h00;
			rx   <= 8'h00;
		end else if (ce) begin
			hcnt <= hcnt + 8'h01;
			case (st)
				spe_pkg::hs_wake: begin
					cs_n <= 1'b0; // RULE12
					if (hcnt == 8'(spe_pkg::cs_gap_cycles - 1)) begin
						cs_n <= 1'b1;
						hcnt <= 8'h00;
						st   <= spe_pkg::hs_gap;
					end
				end
				spe_pkg::hs_idle: begin
					hcnt <= 8'h00;
					if (go) begin
						cs_n <= 1'b0;
						txb  <= next_byte;
						si   <= next_byte[7];
						bitn <= 3'h7;
						bidx <= 7'h0;
						st   <= spe_pkg::hs_low;
					end
				end
				spe_pkg::hs_low: begin
					if (half_done) begin
						sck  <= 1'b1;
						hcnt <= 8'h00;
						st   <= spe_pkg::hs_high;
					end
				end
				spe_pkg::hs_high: begin
					if (half_done) begin
						sck  <= 1'b0;
						hcnt <= 8'h00;
						rx   <= {rx[6:0], so_s};
						st   <= spe_pkg::hs_low;
						if (bitn != 3'h0) begin
							bitn <= bitn - 3'h1;
							si   <= txb[bitn - 3'h1];
						end else if (bidx == nbytes - 7'h1)
							st <= spe_pkg::hs_tail; // RULE13
						else begin
							// status rewrite frames use this same path
							txb  <= next_byte; // RULE17
							si   <= next_byte[7];
							bitn <= 3'h7;
							bidx <= bidx + 7'h1;
						end
					end
				end
				spe_pkg::hs_tail: begin
					if (half_done) begin
						cs_n <= 1'b1; // RULE3 RULE4
						hcnt <= 8'h00;
						st   <= spe_pkg::hs_gap;
					end
				end
				spe_pkg::hs_gap: begin
					if (hcnt == 8'(spe_pkg::cs_gap_cycles - 1))
						st <= spe_pkg::hs_idle;
				end
				default: st <= spe_pkg::hs_idle;
			endcase
		end
	end
endmodule

// >>> dv/spe_link_assertions.sv
// link checker for the serial eeprom pair
module spe_link_assertions #(
	parameter int write_cycles = 100
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	input wire logic busy,
	input wire logic write_latch_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] busy_len;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			busy_len <= 16'h0000;
		else
			busy_len <= busy ? busy_len + 16'h0001 : 16'h0000;
	wr_select_a: assert property ($rose(busy) |-> $past(cs_n, 2))
		else $error("write cycle began with select low");
	wr_latch_a: assert property ($rose(busy) |-> $past(write_latch_flag))
		else $error("write cycle began without latch");
	end_pair_a: assert property ($fell(busy) |-> $fell(write_latch_flag))
		else $error("busy and latch did not clear together");
	cycle_len_a: assert property ($fell(busy) |->
		busy_len >= write_cycles - 2 && busy_len <= write_cycles + 2)
		else $error("write cycle length wrong");
	latch_set_a: assert property ($rose(write_latch_flag) |-> cs_n && !busy)
		else $error("latch set at wrong moment");
	power_up_a: assert property ($rose(hresetn) |->
		!so_oe && !busy && !write_latch_flag)
		else $error("bad state after power-up");
	out_float_a: assert property (cs_n [*6] |-> !so_oe)
		else $error("output driven while deselected");
	busy_ones_a: assert property (busy && so_oe && $past(so_oe, 4) |-> so)
		else $error("status not all ones while busy");
	sck_idle_a: assert property (cs_n |-> !sck)
		else $error("clock moved while deselected");
	cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
		else $error("select gap too short");
	si_hold_a: assert property (sck && $past(sck) |-> $stable(si))
		else $error("input changed while clock high");
	cover property ($fell(busy));
	cover property ($rose(so_oe));
	cover property ($rose(write_latch_flag));
endmodule

// >>> dv/spi_eeprom_write_path_tb.sv
// self-checking bench for the serial eeprom controller and device pair
module spi_eeprom_write_path_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int wc = 1500;
	logic        hclk = 1'h0;
	logic        hresetn = 1'h0;
	logic        hsel = 1'h1;
	logic        hwrite = 1'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        busy;
	logic        write_latch_flag;
	logic [8:0]  peek_addr = 9'h000;
	logic [7:0]  peek_data;
	logic [31:0] rd;
	logic        oe_seen = 1'h0;
	int          errors = 0;
	int          n_compared = 0;
	spe_link_if link ();
	spe_dev #(.write_cycles(wc)) spe_dev_i (.hclk(hclk), .hresetn(hresetn),
		.ce(1'h1), .link(link), .peek_addr(peek_addr), .peek_data(peek_data),
		.busy(busy), .write_latch_flag(write_latch_flag));
	spe_host spe_host_i (.hclk(hclk), .hresetn(hresetn), .ce(1'h1),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .link(link));
	spe_link_assertions #(.write_cycles(wc)) spe_link_assertions_i (
		.hclk(hclk), .hresetn(hresetn), .cs_n(link.cs_n), .sck(link.sck),
		.si(link.si), .so(link.so), .so_oe(link.so_oe), .busy(busy),
		.write_latch_flag(write_latch_flag));
	initial forever #50 hclk = ~hclk;
	always @(posedge hclk) if (link.so_oe === 1'h1) oe_seen <= 1'h1;
	//------------------------------------------------------------
	// bus and link tasks
	//------------------------------------------------------------
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask
	task automatic idle;
		rd = 32'h0000_0001;
		for (int i = 0; i < 4000 && rd[0] !== 1'h0; i++)
			bus(spe_pkg::reg_status, 1'h0, 32'h0000_0000);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [5:0] n = 6'h00,
		input logic ua = 1'h0, input logic [8:0] a = 9'h000,
		input logic [31:0] d = 32'h0000_0000);
		idle();
		bus(spe_pkg::reg_addr, 1'h1, {23'h00_0000, a});
		bus(spe_pkg::reg_wdata, 1'h1, d);
		bus(spe_pkg::reg_ctrl, 1'h1, {15'h0000, ua, 2'h0, n, op});
		idle();
	endtask
	task automatic wr(input logic [7:0] op, input logic [8:0] a,
		input logic [5:0] n, input logic [31:0] d);
		cmd(spe_pkg::write_enable_cmd);
		cmd(op, n, op != spe_pkg::status_write_cmd, a, d);
		for (int i = 0; i < 40 && busy !== 1'h1; i++)
			@(posedge hclk);
	endtask
	task automatic finish_write;
		for (int i = 0; i < 4000 && busy !== 1'h0; i++)
			@(posedge hclk);
		@(posedge hclk);
	endtask
	task automatic peek(input logic [8:0] a);
		@(posedge hclk);
		peek_addr <= a;
		repeat (2) @(posedge hclk);
	endtask
	task automatic end_of_test;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#4000000;
		errors++;
		end_of_test();
	end
	initial begin
		int k;
		repeat (6) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		check({busy, write_latch_flag, link.so_oe}, 9'h000);
		cmd(spe_pkg::status_read_cmd, 6'h01);
		check(rd[15:8], 9'h060);
		$display("power-up test done");
		cmd(spe_pkg::array_write_cmd, 6'h01, 1'h1, 9'h1F5, 32'h0000_003C);
		check({rd[1], busy, hresp}, 9'h004);
		cmd(spe_pkg::write_enable_cmd);
		check(write_latch_flag, 9'h001);
		cmd(spe_pkg::write_disable_cmd);
		check(write_latch_flag, 9'h000);
		oe_seen = 1'h0;
		cmd(8'h03, 6'h01, 1'h0, 9'h000, 32'h0000_0006);
		check({oe_seen, write_latch_flag}, 9'h000);
		cmd(spe_pkg::write_enable_cmd, 6'h03, 1'h0, 9'h000, 32'h0077_F502);
		check({busy, write_latch_flag}, 9'h000);
		$display("latch test done");
		wr(spe_pkg::array_write_cmd, 9'h1F5, 6'h01, 32'h0000_003C);
		check(busy, 9'h001);
		cmd(spe_pkg::status_read_cmd, 6'h01);
		check(rd[15:8], 9'h0FF);
		cmd(spe_pkg::array_write_cmd, 6'h01, 1'h1, 9'h1F5, 32'h0000_0099);
		finish_write();
		check(write_latch_flag, 9'h000);
		peek(9'h1F5);
		check(peek_data, 9'h03C);
		wr(spe_pkg::array_write_cmd, 9'h03E, 6'h12, 32'h4433_2211);
		finish_write();
		for (int o = 0; o < 16; o++) begin
			peek(9'h030 + 9'(o));
			k = (o + 2) % 16 + (((o + 2) % 16 < 2) ? 16 : 0);
			check(peek_data, 9'(8'(32'h4433_2211 >> (8 * (k % 4)))));
		end
		$display("array write test done");
		wr(spe_pkg::status_write_cmd, 9'h000, 6'h01, 32'h0000_00FF);
		finish_write();
		cmd(spe_pkg::status_read_cmd, 6'h01);
		check({write_latch_flag, rd[15:8]}, 9'h0FC);
		wr(spe_pkg::array_write_cmd, 9'h1F5, 6'h01, 32'h0000_00AA);
		finish_write();
		peek(9'h1F5);
		check(peek_data, 9'h03C);
		wr(spe_pkg::status_write_cmd, 9'h000, 6'h01, 32'h0000_0000);
		finish_write();
		cmd(spe_pkg::status_read_cmd, 6'h01);
		check(rd[15:8], 9'h060);
		$display("status test done");
		end_of_test();
	end
endmodule
